// ==== rtl/itfd_pkg.sv ====
// package of constants for the input terminal function decoder
package itfd_pkg;
    // ****************************************
    // function codes
    // ****************************************
    localparam int unsigned FC_W = 6;
    localparam logic [5:0] FC_NONE = 6'h00;
    localparam logic [5:0] FC_RUN = 6'h01;
    localparam logic [5:0] FC_STOP = 6'h02;
    localparam logic [5:0] FC_SPD0 = 6'h03;
    localparam logic [5:0] FC_RESET = 6'h07;
    localparam logic [5:0] FC_COAST = 6'h08;
    localparam logic [5:0] FC_EXT_TRIP = 6'h09;
    localparam logic [5:0] FC_HOLD = 6'h0a;
    localparam logic [5:0] FC_JOG_FWD = 6'h0b;
    localparam logic [5:0] FC_JOG_REV = 6'h0c;
    localparam logic [5:0] FC_UP = 6'h0d;
    localparam logic [5:0] FC_DOWN = 6'h0e;
    localparam logic [5:0] FC_FWD = 6'h0f;
    localparam logic [5:0] FC_REV = 6'h10;
    localparam logic [5:0] FC_X = 6'h11;
    localparam logic [5:0] FC_RAMP_LO = 6'h12;
    localparam logic [5:0] FC_TORQUE = 6'h14;
    localparam logic [5:0] FC_FSRC = 6'h15;
    localparam logic [5:0] FC_RAMP_HI = 6'h22;
    // ****************************************
    // register map
    // ****************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] REG_FUNC_BASE = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h21;
    localparam logic [7:0] REG_LEVEL = 8'h22;
    localparam logic [5:0] FUNC_RESET = 6'h00;
    localparam logic [10:0] CFG_RESET = 11'h000;
    // cfg fields
    localparam int unsigned CFG_RUN_SRC = 0;
    localparam int unsigned CFG_STOP_SRC = 1;
    localparam int unsigned CFG_FREQ_DIG = 2;
    localparam int unsigned CFG_WIRE_LSB = 4;
    localparam int unsigned CFG_COMB_LSB = 8;
    localparam logic [1:0] WIRE_TWO = 2'h0;
    localparam logic [1:0] WIRE_THREE = 2'h1;
    localparam logic [2:0] COMB_SECONDARY = 3'h2;
    localparam logic [2:0] COMB_SUM = 3'h3;
    localparam logic [3:0] SPEED_NONE = 4'hf;
    // status fields
    localparam int unsigned ST_RUN = 0;
    localparam int unsigned ST_STOP = 1;
    localparam int unsigned ST_COAST = 2;
    localparam int unsigned ST_FAULT = 3;
    localparam int unsigned ST_HOLD = 4;
    localparam int unsigned ST_JOG_FWD = 5;
    localparam int unsigned ST_JOG_REV = 6;
    localparam int unsigned ST_UP = 7;
    localparam int unsigned ST_DOWN = 8;
    localparam int unsigned ST_RUN_FWD = 9;
    localparam int unsigned ST_RUN_REV = 10;
    localparam int unsigned ST_TORQUE = 11;
    localparam int unsigned ST_FSRC_SEC = 12;
    localparam int unsigned ST_FSRC_SUM = 13;
    localparam int unsigned ST_RAMP_LSB = 16;
    localparam int unsigned ST_SPEED_LSB = 20;
endpackage

// ==== rtl/itfd_top.sv ====
// input terminal function decoder top
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - code zero terminals produce no command
// - code one gives run when terminals rule
// - code two gives stop when terminals rule
// - codes three to six pick preset speed
// - code seven raises fault reset request
// - code eight coasts, output switched off
// - code nine is external fault, stop
// - code ten freezes ramp, blocks run, jog, step and direction
// - codes eleven, twelve jog forward, reverse
// - codes thirteen, fourteen step digital frequency
// - codes fifteen, sixteen set run direction
// - code seventeen is three wire stop input
// - code eighteen is ramp select low bit
// - code twenty selects torque control
// - code 21 with setting two uses secondary
// - code 21 with setting three uses sum
// - speed index binary, all ones selects none
// - codes 34 and 18 pick ramp pair
// - coast stops override all commands but external fault, ramp select and source select
module itfd_top #(
    parameter int unsigned NUM_TERM = 8
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [NUM_TERM-1:0] term_i,
    input wire logic [itfd_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic run_cmd_o,
    output logic stop_cmd_o,
    output logic fault_reset_o,
    output logic coast_stop_o,
    output logic ext_fault_o,
    output logic ramp_hold_o,
    output logic jog_fwd_o,
    output logic jog_rev_o,
    output logic freq_up_o,
    output logic freq_down_o,
    output logic run_fwd_o,
    output logic run_rev_o,
    output logic [3:0] speed_index_o,
    output logic speed_valid_o,
    output logic [1:0] ramp_sel_o,
    output logic torque_mode_o,
    output logic fsrc_secondary_o,
    output logic fsrc_sum_o
);
    import itfd_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ****************************************
    // terminal synchroniser
    // ****************************************
    logic [NUM_TERM-1:0] term_meta;
    logic [NUM_TERM-1:0] term_lvl;

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            term_meta <= '0;
            term_lvl <= '0;
        end
        else
        begin
            term_meta <= term_i;
            term_lvl <= term_meta;
        end
    end

    // ****************************************
    // register file
    // ****************************************
    logic [FC_W-1:0] func_code [NUM_TERM];
    logic [10:0] cfg;

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int t = 0; t < NUM_TERM; t++)
                func_code[t] <= FUNC_RESET;
        end
        else if (reg_wr_i)
        begin
            for (int t = 0; t < NUM_TERM; t++)
                if (reg_addr_i == REG_FUNC_BASE + ADDR_W'(t))
                    func_code[t] <= reg_wdata_i[FC_W-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            cfg <= CFG_RESET;
        else if (reg_wr_i && reg_addr_i == REG_CFG)
            cfg <= reg_wdata_i[10:0];
    end

    logic run_src_term;
    logic stop_src_term;
    logic freq_dig;
    logic [1:0] wire_mode;
    logic [2:0] comb_set;

    assign run_src_term = cfg[CFG_RUN_SRC];
    assign stop_src_term = cfg[CFG_STOP_SRC];
    assign freq_dig = cfg[CFG_FREQ_DIG];
    assign wire_mode = cfg[CFG_WIRE_LSB +: 2];
    assign comb_set = cfg[CFG_COMB_LSB +: 3];

    // ****************************************
    // function vector
    // ****************************************
    logic [(1<<FC_W)-1:0] fv;

    always_comb
    begin
        fv = '0;
        for (int t = 0; t < NUM_TERM; t++)
            if (func_code[t] != FC_NONE)
                fv[func_code[t]] = fv[func_code[t]] | term_lvl[t];
    end

    // ****************************************
    // decode
    // ****************************************
    logic coast;
    logic fault;
    logic pass;
    logic hold;
    logic fwd_t;
    logic rev_t;
    logic x_t;
    logic fwd_prev;
    logic rev_prev;
    logic reset_prev;
    logic latch_run;
    logic latch_rev;
    logic next_run_fwd;
    logic next_run_rev;
    logic [3:0] spd;

    assign coast = fv[FC_COAST];
    assign fault = fv[FC_EXT_TRIP];
    assign pass = !(coast || fault);
    assign hold = fv[FC_HOLD] && pass;
    assign fwd_t = fv[FC_FWD] && run_src_term;
    assign rev_t = fv[FC_REV] && run_src_term;
    assign x_t = fv[FC_X];
    assign spd = {fv[FC_SPD0+6'h3], fv[FC_SPD0+6'h2], fv[FC_SPD0+6'h1], fv[FC_SPD0]};

    // three wire latch
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fwd_prev <= 1'b0;
            rev_prev <= 1'b0;
            latch_run <= 1'b0;
            latch_rev <= 1'b0;
        end
        else
        begin
            fwd_prev <= fwd_t;
            rev_prev <= rev_t;
            if (wire_mode != WIRE_THREE || !x_t || !pass)
                latch_run <= 1'b0;
            else if (fwd_t && !fwd_prev)
            begin
                latch_run <= 1'b1;
                latch_rev <= 1'b0;
            end
            else if (rev_t && !rev_prev)
            begin
                latch_run <= 1'b1;
                latch_rev <= 1'b1;
            end
        end
    end

    always_comb
    begin
        next_run_fwd = 1'b0;
        next_run_rev = 1'b0;
        if (pass)
        begin
            case (wire_mode)
                WIRE_THREE:
                begin
                    next_run_fwd = latch_run && !latch_rev;
                    next_run_rev = latch_run && latch_rev;
                end
                WIRE_TWO:
                begin
                    next_run_fwd = fwd_t && !rev_t;
                    next_run_rev = rev_t && !fwd_t;
                end
                default:
                begin
                    next_run_fwd = 1'b0;
                    next_run_rev = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // command outputs
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_cmd_o <= 1'b0;
            stop_cmd_o <= 1'b0;
            fault_reset_o <= 1'b0;
            reset_prev <= 1'b0;
            coast_stop_o <= 1'b0;
            ext_fault_o <= 1'b0;
            ramp_hold_o <= 1'b0;
            jog_fwd_o <= 1'b0;
            jog_rev_o <= 1'b0;
            freq_up_o <= 1'b0;
            freq_down_o <= 1'b0;
            run_fwd_o <= 1'b0;
            run_rev_o <= 1'b0;
            speed_index_o <= SPEED_NONE;
            speed_valid_o <= 1'b0;
            ramp_sel_o <= 2'h0;
            torque_mode_o <= 1'b0;
            fsrc_secondary_o <= 1'b0;
            fsrc_sum_o <= 1'b0;
        end
        else
        begin
            run_cmd_o <= fv[FC_RUN] && run_src_term && pass && !hold;
            stop_cmd_o <= fv[FC_STOP] && stop_src_term && pass;
            reset_prev <= fv[FC_RESET];
            fault_reset_o <= fv[FC_RESET] && !reset_prev && pass;
            coast_stop_o <= coast;
            ext_fault_o <= fault;
            ramp_hold_o <= hold;
            jog_fwd_o <= fv[FC_JOG_FWD] && !fv[FC_JOG_REV] && pass && !hold;
            jog_rev_o <= fv[FC_JOG_REV] && !fv[FC_JOG_FWD] && pass && !hold;
            freq_up_o <= fv[FC_UP] && !fv[FC_DOWN] && freq_dig && pass && !hold;
            freq_down_o <= fv[FC_DOWN] && !fv[FC_UP] && freq_dig && pass && !hold;
            run_fwd_o <= next_run_fwd && !hold;
            run_rev_o <= next_run_rev && !hold;
            speed_index_o <= spd;
            speed_valid_o <= (spd != SPEED_NONE) && pass;
            ramp_sel_o <= {fv[FC_RAMP_HI], fv[FC_RAMP_LO]};
            torque_mode_o <= fv[FC_TORQUE] && pass;
            fsrc_secondary_o <= fv[FC_FSRC] && comb_set == COMB_SECONDARY;
            fsrc_sum_o <= fv[FC_FSRC] && comb_set == COMB_SUM;
        end
    end

    // ****************************************
    // register read
    // ****************************************
    logic [31:0] status;
    logic [31:0] next_rdata;

    always_comb
    begin
        status = '0;
        status[ST_RUN] = run_cmd_o;
        status[ST_STOP] = stop_cmd_o;
        status[ST_COAST] = coast_stop_o;
        status[ST_FAULT] = ext_fault_o;
        status[ST_HOLD] = ramp_hold_o;
        status[ST_JOG_FWD] = jog_fwd_o;
        status[ST_JOG_REV] = jog_rev_o;
        status[ST_UP] = freq_up_o;
        status[ST_DOWN] = freq_down_o;
        status[ST_RUN_FWD] = run_fwd_o;
        status[ST_RUN_REV] = run_rev_o;
        status[ST_TORQUE] = torque_mode_o;
        status[ST_FSRC_SEC] = fsrc_secondary_o;
        status[ST_FSRC_SUM] = fsrc_sum_o;
        status[ST_RAMP_LSB +: 2] = ramp_sel_o;
        status[ST_SPEED_LSB +: 4] = speed_index_o;
    end

    always_comb
    begin
        next_rdata = '0;
        if (reg_addr_i == REG_CFG)
            next_rdata = {21'h0, cfg};
        else if (reg_addr_i == REG_STATUS)
            next_rdata = status;
        else if (reg_addr_i == REG_LEVEL)
            next_rdata = 32'(term_lvl);
        else
            for (int t = 0; t < NUM_TERM; t++)
                if (reg_addr_i == REG_FUNC_BASE + ADDR_W'(t))
                    next_rdata = {26'h0, func_code[t]};
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_o <= 32'h0;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
        else
            reg_rdata_o <= 32'h0;
    end
endmodule

// ==== bench/itfd_switch_model.sv ====
// switch bank model driving the terminal inputs
`timescale 1ns/1ps
module itfd_switch_model (
    input wire logic [7:0] want_i,
    output logic [7:0] term_o
);
    // ****************************************
    // contacts, settle off the clock edge
    // ****************************************
    initial term_o = 8'h00;
    always @(want_i) term_o <= #1.5 want_i;
endmodule

// ==== bench/itfd_top_props.sv ====
// checker for the decoded command outputs
`timescale 1ns/1ps
module itfd_top_props (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic run_cmd_o,
    input wire logic stop_cmd_o,
    input wire logic fault_reset_o,
    input wire logic coast_stop_o,
    input wire logic ext_fault_o,
    input wire logic ramp_hold_o,
    input wire logic jog_fwd_o,
    input wire logic jog_rev_o,
    input wire logic freq_up_o,
    input wire logic freq_down_o,
    input wire logic run_fwd_o,
    input wire logic run_rev_o,
    input wire logic [3:0] speed_index_o,
    input wire logic speed_valid_o,
    input wire logic fsrc_secondary_o,
    input wire logic fsrc_sum_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire busy = run_cmd_o | jog_fwd_o | jog_rev_o | freq_up_o | freq_down_o | run_fwd_o
        | run_rev_o;
    a_coast_masks_all: assert property (coast_stop_o |-> !(busy | stop_cmd_o | ramp_hold_o))
        else $error("coast stop with another command");
    a_trip_masks_all: assert property (ext_fault_o |-> !(busy | stop_cmd_o | speed_valid_o))
        else $error("external fault with another command");
    a_hold_blocks_motion: assert property (ramp_hold_o |-> !busy)
        else $error("motion command during hold");
    a_jog_one_way: assert property (!(jog_fwd_o && jog_rev_o))
        else $error("jog both ways");
    a_freq_one_way: assert property (!(freq_up_o && freq_down_o))
        else $error("up and down together");
    a_dir_one_way: assert property (!(run_fwd_o && run_rev_o))
        else $error("both directions");
    a_speed_none: assert property (speed_valid_o |-> speed_index_o != 4'hf)
        else $error("all ones index marked valid");
    a_fsrc_one_kind: assert property (!(fsrc_secondary_o && fsrc_sum_o))
        else $error("two source modes");
    a_reset_one_pulse: assert property (fault_reset_o |=> !fault_reset_o)
        else $error("reset request longer than one cycle");
    c_run: cover property (run_cmd_o);
    c_pulse: cover property (fault_reset_o);
    c_sum: cover property (fsrc_sum_o);
endmodule
bind itfd_top itfd_top_props u_props (.*);

// ==== bench/itfd_tb_top.sv ====
// testbench for the input terminal function decoder
`timescale 1ns/1ps
module itfd_tb_top;
    import itfd_pkg::*;
    // ****************************************
    // signals and helpers
    // ****************************************
    logic core_clk_i, arst_n_i, reg_wr_i, reg_rd_i, run_cmd_o, stop_cmd_o, fault_reset_o;
    logic coast_stop_o, ext_fault_o, ramp_hold_o, jog_fwd_o, jog_rev_o, freq_up_o;
    logic freq_down_o, run_fwd_o, run_rev_o, speed_valid_o, torque_mode_o;
    logic fsrc_secondary_o, fsrc_sum_o;
    logic [7:0] term_i, want, reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, v;
    logic [3:0] speed_index_o;
    logic [1:0] ramp_sel_o;
    int failures = 0, checks_done = 0, cyc = 0;
    // no speed terminal active reads as index zero, the first preset speed
    localparam logic [31:0] SP = 32'h00000000;
    itfd_top #(.NUM_TERM(8)) DUT (.*);
    itfd_switch_model sw (.want_i(want), .term_o(term_i));
    initial
    begin
        core_clk_i = 0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 0;
        #1 v = reg_rdata_o;
    endtask
    task st(input string n, input logic [31:0] e);
        rd(REG_STATUS);
        chk(n, e, v);
    endtask
    task drive(input logic [7:0] t);
        @(posedge core_clk_i);
        want <= t;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask
    task clr;
        drive(0);
        for (int t = 0; t < 8; t++) wr(REG_FUNC_BASE + 8'(t), 32'h0);
        wr(REG_CFG, 0);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        rd(REG_CFG);
        chk("cfg reset", 0, v);
        rd(8'h30);
        chk("unmapped", 0, v);
        clr;
        drive(8'hff);
        st("code zero", SP);
        rd(REG_LEVEL);
        chk("levels", 32'hff, v);
    endtask
    task t_run;
        clr;
        wr(0, FC_RUN);
        wr(1, FC_STOP);
        wr(2, FC_RUN);
        wr(REG_CFG, 3);
        drive(8'h04);
        st("run or", SP | 1 << ST_RUN);
        drive(8'h02);
        st("stop", SP | 1 << ST_STOP);
        wr(REG_CFG, 0);
        drive(8'h05);
        st("run source", SP);
    endtask
    task t_speed;
        clr;
        for (int t = 0; t < 4; t++) wr(8'(t), FC_SPD0 + t);
        for (int i = 0; i < 16; i++)
        begin
            drive(8'(i));
            chk("index", i, speed_index_o);
            chk("valid", i != 15, speed_valid_o);
        end
    endtask
    task t_pulse;
        clr;
        wr(0, FC_RESET);
        @(posedge core_clk_i);
        want <= 1;
        repeat (3) @(posedge core_clk_i);
        #1 chk("pulse", 1, fault_reset_o);
        @(posedge core_clk_i);
        #1 chk("pulse end", 0, fault_reset_o);
    endtask
    task t_coast;
        clr;
        wr(0, FC_COAST);
        wr(1, FC_EXT_TRIP);
        wr(2, FC_RUN);
        wr(3, FC_STOP);
        wr(4, FC_HOLD);
        wr(REG_CFG, 3);
        drive(8'h0d);
        st("coast", SP | 1 << ST_COAST);
        drive(8'h0e);
        st("trip", SP | 1 << ST_FAULT);
        drive(8'h1c);
        st("hold", SP | 1 << ST_HOLD | 1 << ST_STOP);
    endtask
    task t_jog;
        clr;
        for (int t = 0; t < 4; t++) wr(8'(t), FC_JOG_FWD + t);
        wr(REG_CFG, 4);
        for (int t = 0; t < 4; t++)
        begin
            drive(8'(1 << t));
            st("jog updown", SP | 1 << (ST_JOG_FWD + t));
        end
        drive(8'h03);
        st("jog both", SP);
        wr(REG_CFG, 0);
        drive(8'h04);
        st("up not digital", SP);
    endtask
    task t_dir;
        clr;
        wr(0, FC_FWD);
        wr(1, FC_REV);
        wr(2, FC_X);
        wr(REG_CFG, 1);
        drive(1);
        st("fwd", SP | 1 << ST_RUN_FWD);
        drive(2);
        st("rev", SP | 1 << ST_RUN_REV);
        wr(REG_CFG, 32'h11);
        drive(4);
        st("x only", SP);
        drive(5);
        st("latch", SP | 1 << ST_RUN_FWD);
        drive(4);
        st("held", SP | 1 << ST_RUN_FWD);
        drive(0);
        st("x low", SP);
    endtask
    task t_mode;
        clr;
        wr(0, FC_RAMP_LO);
        wr(1, FC_RAMP_HI);
        for (int i = 0; i < 4; i++)
        begin
            drive(8'(i));
            chk("ramp", i, ramp_sel_o);
        end
        wr(0, FC_TORQUE);
        wr(1, FC_FSRC);
        wr(REG_CFG, 32'h200);
        drive(3);
        st("secondary", SP | 1 << ST_TORQUE | 1 << ST_FSRC_SEC);
        wr(REG_CFG, 32'h300);
        rd(REG_CFG);
        chk("cfg back", 32'h300, v);
        drive(3);
        st("sum", SP | 1 << ST_TORQUE | 1 << ST_FSRC_SUM);
    endtask
    initial
    begin
        arst_n_i = 0;
        reg_wr_i = 0;
        reg_rd_i = 0;
        reg_addr_i = 0;
        reg_wdata_i = 0;
        want = 0;
        repeat (5) @(posedge core_clk_i);
        chk("reset index", 32'hf, speed_index_o);
        arst_n_i <= 1;
        repeat (3) @(posedge core_clk_i);
        t_regs;
        t_run;
        t_speed;
        t_pulse;
        t_coast;
        t_jog;
        t_dir;
        t_mode;
        print_verdict;
    end
endmodule
